/* File: core/wtmr_top.sv */
`timescale 1ns/1ps

// Operation
// - 8-bit up-counter, free-running or wrapping at limit
// - overflow interrupt enabled by software
// - fixed-rate clock is reference clock divided by two
// - four prescaler source choices
// - prescale by powers of two, 1 to 256
// - reset bit or limit write clears count
// - keeps counting and interrupting in wait
// - halts prescaler and count in stop mode
// - stop exit by interrupt keeps state
// - stop exit by reset restores reset state
// - suspends counting during background debug
// - external pin synchronised before edge use
// - four 8-bit software registers
// - overflow flag set, read-then-write-zero clear
// - halt bit holds count, set at reset
// - two-bit source field decode
// - four-bit prescale field decode, high codes 256
module wtmr_top #(
	parameter int COUNT_WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire wtmr_pkg::wtmr_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire wtmr_pkg::wtmr_mode_t mode,
	input wire logic fixed_reference_clock,
	input wire logic external_timer_clock_pin,
	output logic overflow_irq
);

	// =========================================================
	// reset release
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// =========================================================
	// registers
	logic overflow_flag;
	logic overflow_irq_enable;
	logic counter_halt_bit;
	logic [1:0] source_select;
	logic [3:0] prescale_select;
	logic [COUNT_WIDTH-1:0] count;
	logic [COUNT_WIDTH-1:0] wrap_limit_value;
	logic flag_armed;

	logic wr_sc;
	logic wr_clk;
	logic wr_limit;
	logic rd_sc;
	logic timer_reset;
	logic wrap_event;
	logic tick;

	assign wr_sc = bus_req.wr && bus_req.addr == wtmr_pkg::ADDR_STATUS_CONTROL;
	assign wr_clk = bus_req.wr && bus_req.addr == wtmr_pkg::ADDR_CLOCK_CONFIG;
	assign wr_limit = bus_req.wr && bus_req.addr == wtmr_pkg::ADDR_WRAP_LIMIT;
	assign rd_sc = bus_req.rd && bus_req.addr == wtmr_pkg::ADDR_STATUS_CONTROL;
	// a reset bit write or any limit write restarts the count
	assign timer_reset = (wr_sc && bus_req.wdata[wtmr_pkg::SC_COUNTER_RESET]) || wr_limit;

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			overflow_irq_enable <= 1'b0;
			counter_halt_bit <= 1'b1;
		end else if (wr_sc) begin
			overflow_irq_enable <= bus_req.wdata[wtmr_pkg::SC_OVERFLOW_IRQ_ENABLE];
			counter_halt_bit <= bus_req.wdata[wtmr_pkg::SC_COUNTER_HALT];
		end
	end

	// source and prescale changes never touch the count
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			source_select <= 2'h0;
			prescale_select <= 4'h0;
		end else if (wr_clk) begin
			source_select <= bus_req.wdata[wtmr_pkg::CLK_SOURCE_LSB +: 2];
			prescale_select <= bus_req.wdata[wtmr_pkg::CLK_PRESCALE_LSB +: 4];
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wrap_limit_value <= wtmr_pkg::WRAP_LIMIT_RESET;
		end else if (wr_limit) begin
			wrap_limit_value <= bus_req.wdata[COUNT_WIDTH-1:0];
		end
	end

	// =========================================================
	// clock sources
	logic fixed_rise;
	logic pin_rise;
	logic pin_fall;
	logic fixed_half;
	logic fixed_half_d;
	logic fixed_half_rise;
	logic src_edge;

	// sync the reference and halve it on its rising edges
	wtmr_edge_sync u_fixed_sync (
		.core_clk(core_clk),
		.rst_sync_b(rst_sync_b),
		.async_in(fixed_reference_clock),
		.rise_pulse(fixed_rise),
		.fall_pulse()
	);

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			fixed_half <= 1'b0;
			fixed_half_d <= 1'b0;
		end else begin
			if (fixed_rise) begin
				fixed_half <= ~fixed_half;
			end
			fixed_half_d <= fixed_half;
		end
	end

	assign fixed_half_rise = fixed_half & ~fixed_half_d;

	// pin rate must stay under a quarter of the bus clock or edges are lost
	wtmr_edge_sync u_pin_sync (
		.core_clk(core_clk),
		.rst_sync_b(rst_sync_b),
		.async_in(external_timer_clock_pin),
		.rise_pulse(pin_rise),
		.fall_pulse(pin_fall)
	);

	always_comb begin
		case (wtmr_pkg::wtmr_source_t'(source_select))
			wtmr_pkg::WTMR_SRC_BUS: src_edge = 1'b1;
			wtmr_pkg::WTMR_SRC_FIXED: src_edge = fixed_half_rise;
			wtmr_pkg::WTMR_SRC_PIN_FALL: src_edge = pin_fall;
			wtmr_pkg::WTMR_SRC_PIN_RISE: src_edge = pin_rise;
			default: src_edge = 1'b0;
		endcase
	end

	// =========================================================
	// prescaler
	logic counting;
	logic [7:0] prescale_count;
	logic [7:0] prescale_mask;
	logic [3:0] ps_code;

	// stop, debug and halt alike freeze the prescaler and the count
	assign counting = !counter_halt_bit && !mode.stop_mode && !mode.debug_mode;
	assign ps_code = (prescale_select > wtmr_pkg::PRESCALE_MAX_CODE) ?
		wtmr_pkg::PRESCALE_MAX_CODE : prescale_select;
	assign prescale_mask = 8'((9'h001 << ps_code) - 9'h001);

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prescale_count <= wtmr_pkg::PRESCALE_ZERO;
		end else if (timer_reset) begin
			prescale_count <= wtmr_pkg::PRESCALE_ZERO;
		end else if (counting && src_edge) begin
			prescale_count <= prescale_count + 8'h01;
		end
	end

	assign tick = counting && src_edge && ((prescale_count & prescale_mask) == prescale_mask);

	// =========================================================
	// counter
	// a zero limit lets the counter roll through its full range
	assign wrap_event = tick && (wrap_limit_value == '0 ?
		count == '1 : count == wrap_limit_value);

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			count <= wtmr_pkg::COUNT_RESET;
		end else if (timer_reset) begin
			count <= wtmr_pkg::COUNT_RESET;
		end else if (wrap_event) begin
			count <= wtmr_pkg::COUNT_RESET;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	// =========================================================
	// overflow flag: read while set arms a zero-write clear; new wrap wins
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			overflow_flag <= 1'b0;
			flag_armed <= 1'b0;
		end else begin
			if (wrap_event) begin
				overflow_flag <= 1'b1;
			end else if (timer_reset) begin
				overflow_flag <= 1'b0;
			end else if (wr_sc && flag_armed &&
				!bus_req.wdata[wtmr_pkg::SC_OVERFLOW_FLAG]) begin
				overflow_flag <= 1'b0;
			end
			if (rd_sc && overflow_flag) begin
				flag_armed <= 1'b1;
			end else if (wr_sc || !overflow_flag) begin
				flag_armed <= 1'b0;
			end
		end
	end

	// level request; wait mode keeps it live so it can wake the core
	assign overflow_irq = overflow_flag && overflow_irq_enable;

	// =========================================================
	// read port
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdata <= 8'h00;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				wtmr_pkg::ADDR_STATUS_CONTROL: rdata <= {overflow_flag,
					overflow_irq_enable, 1'b0, counter_halt_bit, 4'h0};
				wtmr_pkg::ADDR_CLOCK_CONFIG: rdata <= {2'h0, source_select,
					prescale_select};
				wtmr_pkg::ADDR_CURRENT_COUNT: rdata <= count;
				wtmr_pkg::ADDR_WRAP_LIMIT: rdata <= wrap_limit_value;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

/* File: core/wtmr_pkg.sv */
package wtmr_pkg;

	// =========================================================
	// register offsets (word index on the plain register port)
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_CLOCK_CONFIG = 2'h1;
	localparam logic [1:0] ADDR_CURRENT_COUNT = 2'h2;
	localparam logic [1:0] ADDR_WRAP_LIMIT = 2'h3;
	localparam logic [1:0] ADDR_IRQ_STATUS = 2'h0;

	// =========================================================
	// field positions
	localparam int SC_OVERFLOW_FLAG = 7;
	localparam int SC_OVERFLOW_IRQ_ENABLE = 6;
	localparam int SC_COUNTER_RESET = 5;
	localparam int SC_COUNTER_HALT = 4;
	localparam int CLK_SOURCE_LSB = 4;
	localparam int CLK_PRESCALE_LSB = 0;

	// =========================================================
	// reset values and encodings
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] WRAP_LIMIT_RESET = 8'h00;
	localparam logic [3:0] PRESCALE_MAX_CODE = 4'h8;
	localparam logic [7:0] PRESCALE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		WTMR_SRC_BUS,
		WTMR_SRC_FIXED,
		WTMR_SRC_PIN_FALL,
		WTMR_SRC_PIN_RISE
	} wtmr_source_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wtmr_bus_req_t;

	typedef struct packed {
		logic wait_mode;
		logic stop_mode;
		logic debug_mode;
	} wtmr_mode_t;

endpackage

/* File: core/wtmr_edge_sync.sv */
`timescale 1ns/1ps

// two-stage synchroniser followed by edge detection on the synced copy
module wtmr_edge_sync (
	input wire logic core_clk,
	input wire logic rst_sync_b,
	input wire logic async_in,
	output logic rise_pulse,
	output logic fall_pulse
);

	logic meta;
	logic synced;
	logic synced_d;

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			meta <= 1'b0;
			synced <= 1'b0;
			synced_d <= 1'b0;
		end else begin
			meta <= async_in;
			synced <= meta;
			synced_d <= synced;
		end
	end

	assign rise_pulse = synced & ~synced_d;
	assign fall_pulse = ~synced & synced_d;

endmodule

/* File: tb/wtmr_top_asserts.sv */
`timescale 1ns/1ps
// ====
// port checks
module wtmr_top_asserts #(
	parameter int COUNT_WIDTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire wtmr_pkg::wtmr_bus_req_t bus_req,
	input wire logic [7:0] rdata,
	input wire wtmr_pkg::wtmr_mode_t mode,
	input wire logic fixed_reference_clock,
	input wire logic external_timer_clock_pin,
	input wire logic overflow_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire r0 = bus_req.rd && bus_req.addr == 2'h0;
	wire w0 = bus_req.wr && bus_req.addr == 2'h0;
	a_rdata_idle: assert property (!bus_req.rd |=> rdata == 8'h00)
		else $error("rdata not idle");
	a_sc_reserved: assert property (r0 |=> rdata[5] == 1'b0 && rdata[3:0] == 4'h0)
		else $error("status reserved bits set");
	a_clk_reserved: assert property (bus_req.rd && bus_req.addr == 2'h1 |=> rdata[7:6] == 2'h0)
		else $error("clock config high bits set");
	a_irq_matches: assert property (r0 |=> (rdata[7] && rdata[6]) == $past(overflow_irq))
		else $error("irq differs from flag and enable");
	a_stop_holds: assert property (mode.stop_mode && !bus_req.wr |=> $stable(overflow_irq))
		else $error("irq moved in stop");
	a_debug_holds: assert property (mode.debug_mode && !bus_req.wr |=> $stable(overflow_irq))
		else $error("irq moved in debug");
	a_limit_clears: assert property (mode.stop_mode && bus_req.wr && bus_req.addr == 2'h3
		|=> !overflow_irq)
		else $error("limit write kept irq");
	a_trst_clears: assert property (mode.stop_mode && w0 && bus_req.wdata[5] |=> !overflow_irq)
		else $error("counter reset kept irq");
	a_irq_drop_wr: assert property ($fell(overflow_irq) |-> $past(bus_req.wr))
		else $error("irq fell without write");
endmodule
bind wtmr_top wtmr_top_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.bus_req(bus_req),
	.rdata(rdata),
	.mode(mode),
	.fixed_reference_clock(fixed_reference_clock),
	.external_timer_clock_pin(external_timer_clock_pin),
	.overflow_irq(overflow_irq)
);

/* File: tb/tb_modulo_timer_8bit.sv */
`timescale 1ns/1ps
// ====
// bench
module tb_modulo_timer_8bit;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	wtmr_pkg::wtmr_bus_req_t bus_req = '0;
	wtmr_pkg::wtmr_mode_t mode = '0;
	logic fref = 1'b0;
	logic pin = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic [7:0] d;
	logic [7:0] d0;
	logic [31:0] seed = 32'h5;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int lim;
	int ex[4] = '{200, 17, 25, 25};
	wtmr_top #(.COUNT_WIDTH(8)) DUT (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
		.rdata(rdata), .mode(mode), .fixed_reference_clock(fref),
		.external_timer_clock_pin(pin), .overflow_irq(irq));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// pin kept at an eighth of the bus rate, well inside the quarter limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) pin <= ~pin;
		if (cyc % 3 == 2) fref <= ~fref;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [7:0] got, input int e, input int t);
		compares++;
		if ($isunknown(got) || got > e + t || got + t < e) begin
			failures++;
			$display("mismatch %s exp %0d seen %0d", n, e, got);
		end
	endtask
	task automatic rc(input string n, input logic [1:0] a, input int e, input int t);
		@(posedge core_clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rdata;
		chk(n, d, e, t);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		wt(30000);
		failures++;
		tally_and_finish();
	end
	initial begin
		wt(12);
		rst_b <= 1'b1;
		wt(4);
		rc("sc", 2'h0, 16, 0);
		rc("clk", 2'h1, 0, 0);
		rc("cnt", 2'h2, 0, 0);
		rc("lim", 2'h3, 0, 0);
		wr(2'h1, 8'h3f);
		rc("clk", 2'h1, 63, 0);
		wr(2'h2, 8'h55);
		rc("cnt", 2'h2, 0, 0);
		$display("test regs done");
		for (int s = 0; s < 4; s++) begin
			wr(2'h1, 8'(s * 16));
			wr(2'h3, 8'h00);
			wr(2'h0, 8'h00);
			wt(200);
			wr(2'h0, 8'h10);
			rc("source", 2'h2, ex[s], 3);
		end
		$display("test sources done");
		for (int p = 0; p < 10; p++) begin
			wr(2'h1, 8'(p));
			wr(2'h3, 8'h00);
			wr(2'h0, 8'h00);
			wt(4 << (p > 8 ? 8 : p));
			wr(2'h0, 8'h10);
			rc("prescale", 2'h2, ((4 << (p > 8 ? 8 : p)) + 2) >> (p > 8 ? 8 : p), 1);
		end
		$display("test prescale done");
		for (int i = 0; i < 2; i++) begin
			wr(2'h1, 8'h00);
			wr(2'h3, 8'h00);
			wr(2'h0, 8'h00);
			wt(20);
			mode <= '{1'b0, i == 0, i == 1};
			// second pass starts with the counter already running, two extra ticks
			rc("freeze", 2'h2, i == 0 ? 20 : 22, 0);
			d0 = d;
			wt(30);
			rc("frozen", 2'h2, d0, 0);
			wt(1);
			mode <= '0;
			wt(10);
			rc("resumed", 2'h2, d0 + 11, 0);
		end
		$display("test modes done");
		wr(2'h3, 8'h03);
		wr(2'h0, 8'h00);
		wt(20);
		#1;
		chk("masked", irq, 0, 0);
		rc("sc", 2'h0, 128, 0);
		wr(2'h0, 8'h40);
		mode <= '{1'b1, 1'b0, 1'b0};
		for (int k = 0; k < 20 && irq !== 1'b1; k++) begin
			wt(1);
			#1;
		end
		chk("irq", irq, 1, 0);
		rc("sc", 2'h0, 192, 0);
		wt(1);
		mode <= '{1'b0, 1'b1, 1'b0};
		wr(2'h0, 8'h50);
		#1;
		chk("irqclr", irq, 0, 0);
		wr(2'h0, 8'h70);
		wr(2'h3, 8'h03);
		mode <= '0;
		$display("test irq done");
		// model: one tick per cycle, first pass starts halted, later ones already counting
		for (int r = 0; r < 3; r++) begin
			lim = int'(xs() % 32'd254) + 1;
			wr(2'h3, 8'(lim));
			wr(2'h0, 8'h00);
			for (int k = 0; k < 8; k++) begin
				rc("bound", 2'h2, ((r == 0 ? 1 : 3) + 2 * k) % (lim + 1), 0);
			end
		end
		$display("test limits done");
		wt(1);
		rst_b <= 1'b0;
		wt(2);
		rst_b <= 1'b1;
		wt(4);
		rc("sc", 2'h0, 16, 0);
		rc("cnt", 2'h2, 0, 0);
		rc("lim", 2'h3, 0, 0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule
